/* arw_checker.sv */
// Checker: bus, conversion and interrupt timing at the top ports.
// Assumes one clock and that the bench sets the divider to 0.
`timescale 1ns/1ps
`default_nettype none
module arw_checker (
  // Watched ports
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [11:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  input wire [31:0] dat_o,
  input wire ack_o,
  input wire [9:0] sar_code_i,
  input wire sar_busy_o,
  input wire irq_o
);
  // ------------------------------------------------
  // Properties
  // ------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire take = cyc_i && stb_i && !ack_o;
  // Control register byte address is 0x3A0
  wire go = take && we_i && sel_i[0] && adr_i == 12'h3A0 && dat_i[4];
  ack_pulse_a:
    assert property (ack_o |=> !ack_o) else $error("ack held too long");
  ack_answer_a:
    assert property (take |=> ack_o) else $error("request not acked");
  ack_cause_a:
    assert property (ack_o |-> $past(take)) else $error("stray ack");
  busy_start_a:
    assert property (go && !sar_busy_o |-> ##[1:3] sar_busy_o)
    else $error("start did not raise busy");
  busy_len_a:
    assert property ($rose(sar_busy_o) |-> sar_busy_o[*8])
    else $error("conversion ended early");
  irq_rise_a:
    assert property ($rose(irq_o) |->
      ($past(sar_busy_o, 2) && !$past(sar_busy_o)) ||
      (ack_o && $past(we_i))) else $error("irq rose without cause");
  irq_fall_a:
    assert property ($fell(irq_o) |-> (ack_o && $past(we_i)) ||
      $past(rst_i)) else $error("flag lost without a write");
  dat_hold_a:
    assert property ($changed(dat_o) |-> ack_o || $past(rst_i))
    else $error("read data changed between reads");
endmodule // arw_checker
bind arw_top arw_checker u_arw_chk (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .sar_code_i(sar_code_i), .sar_busy_o(sar_busy_o), .irq_o(irq_o));
`default_nettype wire

/* arw_conv_timer.v */
// Conversion timer: divides the system clock into SAR clocks and
// counts one conversion. Assumes start is a one-cycle request.
`timescale 1ns/1ps
`default_nettype none
`include "arw_defines.vh"

module arw_conv_timer #(
  parameter DIV_W = 5,
  parameter CONV_CLKS = `ARW_CONV_CLKS
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Control
  input wire start_i,
  input wire [DIV_W-1:0] div_i,
  // Status
  output wire busy_o,
  output reg done_o
);

  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_CONV = 2'b10;
  // Count is cut to the 5-bit counter on purpose
  localparam [31:0] LAST_FULL = CONV_CLKS - 1;
  localparam [4:0] LAST = LAST_FULL[4:0];

  reg [1:0] state_q;
  reg [DIV_W-1:0] pre_q;
  reg [4:0] cnt_q;
  wire tick;

  // SAR clock period is div+1 system clocks
  assign tick = (pre_q == div_i);
  assign busy_o = state_q[1];

  always @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      pre_q <= {DIV_W{1'b0}};
      cnt_q <= 5'h00;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          // Starts during a conversion are ignored, not queued
          if (start_i) begin
            state_q <= ST_CONV;
            pre_q <= {DIV_W{1'b0}};
            cnt_q <= 5'h00;
          end
        end
        ST_CONV: begin
          pre_q <= tick ? {DIV_W{1'b0}} : pre_q + 1'b1;
          if (tick) begin
            cnt_q <= cnt_q + 5'h01;
            if (cnt_q == LAST) begin
              state_q <= ST_IDLE;
              done_o <= 1'b1;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

endmodule // arw_conv_timer

`default_nettype wire

/* arw_defines.vh */
// Constants for the converter result formatting and window detect block.
// Assumes a 32-bit classic Wishbone bus, one register per aligned word.
//
// Notes on behaviour
// - Right-justified results put code bits 9:8 in high byte 1:0, rest low.
// - Right-justified high byte 7:2 sign-extend differential, zero otherwise.
// - Left-justified results fill high byte and low 7:6, low 5:0 are zero.
// - Code is 10-bit unsigned single-ended, 10-bit two's complement diff.
// - Every finished conversion is compared with both limit words.
// - A window hit sets the window flag and interrupts when unmasked.
// - The window flag stays readable so software can poll it.
// - Each limit word is two separately writable bytes, upper and lower.
// - Limit ordering selects flagging inside or outside the window.
// - The upper-limit high byte sits at index 0xC7 and resets to zero.
// - A conversion lasts 16 SAR clock periods before the result lands.
`ifndef ARW_DEFINES_VH
`define ARW_DEFINES_VH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define ARW_IDX_RES_LO 8'hBE
`define ARW_IDX_RES_HI 8'hBF
`define ARW_IDX_STATUS 8'hC0
`define ARW_IDX_MASK 8'hC1
`define ARW_IDX_CFG 8'hC2
`define ARW_IDX_DIV 8'hC3
`define ARW_IDX_GT_LO 8'hC4
`define ARW_IDX_GT_HI 8'hC5
`define ARW_IDX_LT_LO 8'hC6
`define ARW_IDX_LT_HI 8'hC7
`define ARW_IDX_CTRL 8'hE8

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ARW_CTRL_LJ 0
`define ARW_CTRL_WIN 1
`define ARW_CTRL_BUSY 4
`define ARW_CTRL_DONE 5
`define ARW_ST_DONE 0
`define ARW_ST_WIN 1
`define ARW_CFG_DIFF 0

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define ARW_LIMIT_RST 8'h00
`define ARW_RES_RST 8'h00
`define ARW_DIV_RST 5'h1F
`define ARW_CONV_CLKS 16

`endif

/* arw_fmt.v */
// Result justification and window comparison, purely combinational.
// Assumes the raw code is stable in the cycle a conversion completes.
`timescale 1ns/1ps
`default_nettype none

module arw_fmt (
  // Raw code and format
  input wire [9:0] code_i,
  input wire lj_i,
  input wire diff_i,
  // Limits
  input wire [15:0] gt_i,
  input wire [15:0] lt_i,
  // Results
  output reg [15:0] word_o,
  output wire match_o
);

  // Signed compare for differential words, unsigned otherwise
  function lt_f;
    input [15:0] a;
    input [15:0] b;
    input sgn;
    begin
      lt_f = sgn ? ($signed(a) < $signed(b)) : (a < b);
    end
  endfunction

  wire sign_ext;
  wire lt_above;
  wire below_lt;
  wire above_gt;

  // Differential codes are already two's complement from the SAR
  assign sign_ext = diff_i & code_i[9];

  always @* begin
    if (lj_i) begin
      word_o = {code_i, 6'h00};
    end else begin
      word_o = {{6{sign_ext}}, code_i};
    end
  end

  // Limits are read in the same justification and sign as the result
  assign lt_above = lt_f(gt_i, lt_i, diff_i);
  assign below_lt = lt_f(word_o, lt_i, diff_i);
  assign above_gt = lt_f(gt_i, word_o, diff_i);
  assign match_o = lt_above ? (below_lt & above_gt)
                            : (below_lt | above_gt);

endmodule // arw_fmt

`default_nettype wire

/* arw_top.v */
// Converter result formatting and window detect with a Wishbone slave.
// Assumes a classic Wishbone master and a SAR core presenting its raw
// 10-bit code on sar_code_i when the conversion time has elapsed.
//
// The Wishbone slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "arw_defines.vh"

module arw_top #(
  parameter DIV_W = 5,
  parameter CONV_CLKS = `ARW_CONV_CLKS
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Wishbone slave
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [11:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  // SAR core
  input wire [9:0] sar_code_i,
  output wire sar_busy_o,
  // Interrupt
  output wire irq_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  reg lj_q;
  reg diff_q;
  reg [DIV_W-1:0] div_q;
  reg [1:0] status_q;
  reg [1:0] status_d;
  reg [1:0] mask_q;
  reg [7:0] res_hi_q;
  reg [7:0] res_lo_q;
  reg [7:0] gth_q;
  reg [7:0] gtl_q;
  reg [7:0] lth_q;
  reg [7:0] ltl_q;
  reg [31:0] rd_d;
  reg start_q;

  wire req;
  wire wr;
  wire [7:0] idx;
  wire [7:0] wd;
  wire busy;
  wire done;
  wire [15:0] word;
  wire match;
  wire [1:0] events;
  wire [1:0] clr;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function hit;
    input [7:0] a;
    input [7:0] b;
    begin
      hit = (a == b);
    end
  endfunction

  // Word index; the two low address bits are ignored
  assign idx = adr_i[9:2];
  assign req = cyc_i & stb_i & ~ack_o;
  // No register is wider than 8 bits, so only lane 0 carries writes
  assign wr = req & we_i & sel_i[0] & (adr_i[11:10] == 2'b00);
  assign wd = dat_i[7:0];

  // ----------------------------------------------------------------
  // Bus answer
  // ----------------------------------------------------------------
  // One wait-free cycle: ack the edge after the request is seen,
  // drop it the next cycle so back-to-back cycles see a gap
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= req;
      if (req & ~we_i) begin
        dat_o <= rd_d;
      end
    end
  end

  always @* begin
    rd_d = 32'h0000_0000;
    if (adr_i[11:10] == 2'b00) begin
      case (idx)
        `ARW_IDX_RES_LO: rd_d[7:0] = res_lo_q;
        `ARW_IDX_RES_HI: rd_d[7:0] = res_hi_q;
        `ARW_IDX_STATUS: rd_d[1:0] = status_q;
        `ARW_IDX_MASK: rd_d[1:0] = mask_q;
        `ARW_IDX_CFG: rd_d[`ARW_CFG_DIFF] = diff_q;
        `ARW_IDX_DIV: rd_d[DIV_W-1:0] = div_q;
        `ARW_IDX_GT_LO: rd_d[7:0] = gtl_q;
        `ARW_IDX_GT_HI: rd_d[7:0] = gth_q;
        `ARW_IDX_LT_LO: rd_d[7:0] = ltl_q;
        `ARW_IDX_LT_HI: rd_d[7:0] = lth_q;
        `ARW_IDX_CTRL: begin
          rd_d[`ARW_CTRL_LJ] = lj_q;
          rd_d[`ARW_CTRL_WIN] = status_q[`ARW_ST_WIN];
          rd_d[`ARW_CTRL_BUSY] = busy;
          rd_d[`ARW_CTRL_DONE] = status_q[`ARW_ST_DONE];
        end
        default: rd_d = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Configuration and limit registers
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      lj_q <= 1'b0;
      diff_q <= 1'b0;
      div_q <= `ARW_DIV_RST;
      mask_q <= 2'b00;
      gth_q <= `ARW_LIMIT_RST;
      gtl_q <= `ARW_LIMIT_RST;
      lth_q <= `ARW_LIMIT_RST;
      ltl_q <= `ARW_LIMIT_RST;
      start_q <= 1'b0;
    end else begin
      start_q <= 1'b0;
      if (wr) begin
        if (hit(idx, `ARW_IDX_CTRL)) begin
          lj_q <= wd[`ARW_CTRL_LJ];
          start_q <= wd[`ARW_CTRL_BUSY];
        end
        if (hit(idx, `ARW_IDX_CFG)) begin
          diff_q <= wd[`ARW_CFG_DIFF];
        end
        if (hit(idx, `ARW_IDX_DIV)) begin
          div_q <= wd[DIV_W-1:0];
        end
        if (hit(idx, `ARW_IDX_MASK)) begin
          mask_q <= wd[1:0];
        end
        if (hit(idx, `ARW_IDX_GT_HI)) begin
          gth_q <= wd;
        end
        if (hit(idx, `ARW_IDX_GT_LO)) begin
          gtl_q <= wd;
        end
        if (hit(idx, `ARW_IDX_LT_HI)) begin
          lth_q <= wd;
        end
        if (hit(idx, `ARW_IDX_LT_LO)) begin
          ltl_q <= wd;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Conversion timing
  // ----------------------------------------------------------------
  arw_conv_timer #(
    .DIV_W(DIV_W),
    .CONV_CLKS(CONV_CLKS)
  ) u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(start_q),
    .div_i(div_q),
    .busy_o(busy),
    .done_o(done)
  );

  assign sar_busy_o = busy;

  // ----------------------------------------------------------------
  // Formatting and window compare
  // ----------------------------------------------------------------
  arw_fmt u_fmt (
    .code_i(sar_code_i),
    .lj_i(lj_q),
    .diff_i(diff_q),
    .gt_i({gth_q, gtl_q}),
    .lt_i({lth_q, ltl_q}),
    .word_o(word),
    .match_o(match)
  );

  // ----------------------------------------------------------------
  // Result registers
  // ----------------------------------------------------------------
  // A software write in the completing cycle loses to the new result
  always @(posedge clk_i) begin
    if (rst_i) begin
      res_hi_q <= `ARW_RES_RST;
      res_lo_q <= `ARW_RES_RST;
    end else if (done) begin
      res_hi_q <= word[15:8];
      res_lo_q <= word[7:0];
    end else if (wr) begin
      if (hit(idx, `ARW_IDX_RES_HI)) begin
        res_hi_q <= wd;
      end
      if (hit(idx, `ARW_IDX_RES_LO)) begin
        res_lo_q <= wd;
      end
    end
  end

  // ----------------------------------------------------------------
  // Event flags and interrupt
  // ----------------------------------------------------------------
  // Every completion is checked with no software step
  assign events[`ARW_ST_DONE] = done;
  assign events[`ARW_ST_WIN] = done & match;

  // Write one to clear; the control register may clear both flags too
  assign clr = (wr & hit(idx, `ARW_IDX_STATUS)) ? wd[1:0] :
               (wr & hit(idx, `ARW_IDX_CTRL)) ?
               ~{wd[`ARW_CTRL_WIN], wd[`ARW_CTRL_DONE]} : 2'b00;

  // Set beats clear so a hit in the clearing cycle is kept
  always @* begin
    status_d = (status_q & ~clr) | events;
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      status_q <= 2'b00;
    end else begin
      status_q <= status_d;
    end
  end

  assign irq_o = |(status_q & mask_q);

endmodule // arw_top

`default_nettype wire

/* testbench.sv */
// Testbench: register map, result format, window flag and interrupt.
// Assumes the design acks every request; divider 0 for conversions.
`timescale 1ns/1ps
`default_nettype none
`include "arw_defines.vh"
module testbench;
  // ------------------------------------------------
  // Signals and helpers
  // ------------------------------------------------
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
  logic [11:0] adr_i = 0;
  logic [3:0] sel_i = 0;
  logic [31:0] dat_i = 0, rnd = 32'h5C030D85;
  logic [9:0] sar_code_i = 0, code;
  logic [15:0] w, a, b, g, t;
  logic [7:0] ad;
  logic win;
  int fail_count = 0, check_count = 0, n;
  logic [31:0] exp_q[$];
  wire [31:0] dat_o;
  wire ack_o, sar_busy_o, irq_o;
  always #10 clk_i = ~clk_i;
  arw_top #(.DIV_W(5), .CONV_CLKS(16)) dut (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .sar_code_i(sar_code_i), .sar_busy_o(sar_busy_o), .irq_o(irq_o));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [15:0] fmt(input logic [9:0] c, input logic l, d);
    return l ? {c, 6'h00} : {{6{d & c[9]}}, c};
  endfunction
  // Flipping the sign bit lets one unsigned compare serve both formats
  function automatic logic hit(input logic [15:0] x, gt, lt, input logic d);
    logic [15:0] f;
    f = {d, 15'h0000};
    x = x ^ f;
    gt = gt ^ f;
    lt = lt ^ f;
    return (lt > gt) ? (x > gt && x < lt) : (x < lt || x > gt);
  endfunction
  task automatic fail(input string m);
    fail_count++;
    $display("wrong value at %0t: %s", $time, m);
  endtask
  task automatic chk(input logic v, e);
    check_count++;
    if (v !== e) fail("flag");
  endtask
  task automatic wb(input logic wr_en, input logic [7:0] i, d,
      input logic [3:0] s);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= wr_en;
    sel_i <= s;
    adr_i <= {2'b00, i, 2'b00};
    dat_i <= {24'h000000, d};
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] i, d);
    wb(1'b1, i, d, 4'hF);
  endtask
  task automatic rd(input logic [7:0] i, d);
    exp_q.push_back({24'h000000, d});
    wb(1'b0, i, 8'h00, 4'hF);
  endtask
  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && we_i === 1'b0 && exp_q.size() > 0) begin
      check_count++;
      if (dat_o !== exp_q[0]) fail("read data");
      void'(exp_q.pop_front());
    end
  end
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ------------------------------------------------
  // Tests
  // ------------------------------------------------
  initial begin
    repeat (20000) @(posedge clk_i);
    fail("timeout");
    end_of_test;
  end
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`ARW_IDX_LT_HI, 8'h00);
    rd(`ARW_IDX_DIV, 8'h1F);
    wr(8'h10, 8'h5A);
    rd(8'h10, 8'h00);
    wb(1'b1, `ARW_IDX_LT_HI, 8'hA5, 4'hE);
    rd(`ARW_IDX_LT_HI, 8'h00);
    for (ad = 8'hC4; ad <= 8'hC7; ad++) begin
      rnd = lfsr(rnd);
      wr(ad, rnd[7:0]);
      rd(ad, rnd[7:0]);
    end
    $display("test register map done");
    wr(`ARW_IDX_DIV, 8'h00);
    for (int i = 0; i < 16; i++) begin
      rnd = lfsr(rnd);
      code = rnd[9:0];
      w = fmt(code, i[0], i[1]);
      a = fmt(rnd[25:16], i[0], i[1]);
      // Second half (i 8 to 15) puts a limit exactly on the result: strict compare
      b = i[3] ? w : fmt(rnd[31:22], i[0], i[1]);
      g = i[2] ? a : b;
      t = i[2] ? b : a;
      win = hit(w, g, t, i[1]);
      wr(`ARW_IDX_CFG, {7'h00, i[1]});
      wr(`ARW_IDX_GT_LO, g[7:0]);
      wr(`ARW_IDX_GT_HI, g[15:8]);
      wr(`ARW_IDX_LT_LO, t[7:0]);
      wr(`ARW_IDX_LT_HI, t[15:8]);
      wr(`ARW_IDX_STATUS, 8'h03);
      sar_code_i <= code;
      wr(`ARW_IDX_CTRL, {7'h08, i[0]});
      n = 0;
      while (sar_busy_o !== 1'b1 && n < 3) begin
        @(posedge clk_i);
        n++;
      end
      n = 0;
      while (sar_busy_o === 1'b1 && n < 99) begin
        @(posedge clk_i);
        n++;
      end
      chk(n >= 16 && n <= 17, 1'b1);
      rd(`ARW_IDX_RES_LO, w[7:0]);
      rd(`ARW_IDX_RES_HI, w[15:8]);
      rd(`ARW_IDX_STATUS, {6'h00, win, 1'b1});
      rd(`ARW_IDX_CTRL, {2'b00, 1'b1, 3'b000, win, i[0]});
      chk(irq_o, 1'b0);
      wr(`ARW_IDX_MASK, 8'h02);
      chk(irq_o, win);
      wr(`ARW_IDX_STATUS, 8'h03);
      chk(irq_o, 1'b0);
      wr(`ARW_IDX_MASK, 8'h00);
    end
    $display("test conversions done");
    @(posedge clk_i);
    end_of_test;
  end
endmodule // testbench
`default_nettype wire
